/* File: core/tla_pkg.sv */
// Shared constants and types of the limit alarm back end.
// Assumes one clock and a byte-wide register port to the serial host logic.
package tla_pkg;
  localparam int NUM_CH = 9;
  localparam logic [7:0] ADDR_STAT1 = 8'h00;
  localparam logic [7:0] ADDR_STAT2 = 8'h01;
  localparam logic [7:0] ADDR_LSB_A = 8'h03;
  localparam logic [7:0] ADDR_LSB_B = 8'h04;
  localparam logic [7:0] ADDR_LSB_C = 8'h05;
  localparam logic [7:0] ADDR_MSB_VDD = 8'h06;
  localparam logic [7:0] ADDR_MSB_INT = 8'h07;
  localparam logic [7:0] ADDR_MSB_EXT = 8'h08;
  localparam logic [7:0] ADDR_MSB_AIN3 = 8'h0a;
  localparam logic [7:0] ADDR_MSB_LAST = 8'h0f;
  localparam logic [7:0] ADDR_CFG1 = 8'h18;
  localparam logic [7:0] ADDR_CFG2 = 8'h19;
  localparam logic [7:0] ADDR_MASK1 = 8'h1d;
  localparam logic [7:0] ADDR_MASK2 = 8'h1e;
  localparam logic [7:0] ADDR_LIM_BASE = 8'h30;
  localparam logic [7:0] ADDR_LIM_LAST = 8'h41;
  localparam int CFG1_POL_BIT = 3;
  localparam int CFG2_AVG_OFF_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] HIGH_LIM_RESET = 8'h7f;
  localparam logic [7:0] LOW_LIM_RESET = 8'h80;
  localparam logic [9:0] RES_RESET = 10'h000;
  localparam int AVG_COUNT = 16;
  localparam int AVG_SHIFT = 4;
  // Channel numbers of the result store.
  localparam logic [3:0] CH_VDD = 4'h0;
  localparam logic [3:0] CH_INT = 4'h1;
  localparam logic [3:0] CH_EXT = 4'h2;

  typedef struct packed {
    logic [3:0] chan;
    logic [9:0] code;
  } tla_conv_type;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tla_reg_req_type;

  typedef enum logic {
    PH_BASE,
    PH_MULT
  } tla_phase_type;
endpackage : tla_pkg

/* File: core/tla_remote_avg.sv */
// Remote diode bias switching and sixteen-fold averaging.
// Assumes one front-end sample per bias phase, taken on core_clk.
`timescale 1ns/1ps
module tla_remote_avg (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic samp_valid,
  input wire logic [9:0] samp_code,
  input wire logic avg_on,
  output logic bias_mult,
  output logic res_valid,
  output logic [9:0] res_code
);
  tla_pkg::tla_phase_type phase_q;
  logic [9:0] base_q;
  logic [13:0] acc_q;
  logic [4:0] cnt_q;
  logic [9:0] diff;
  logic [13:0] acc_sum;
  logic last;

  assign diff = samp_code - base_q;
  assign acc_sum = acc_q + {{4{diff[9]}}, diff};
  assign last = avg_on ? (cnt_q == 5'(tla_pkg::AVG_COUNT - 1)) : 1'b1;
  assign bias_mult = (phase_q == tla_pkg::PH_MULT);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      phase_q <= tla_pkg::PH_BASE;
      base_q <= tla_pkg::RES_RESET;
      acc_q <= '0;
      cnt_q <= '0;
      res_valid <= 1'b0;
      res_code <= tla_pkg::RES_RESET;
    end else begin
      res_valid <= 1'b0;
      if (samp_valid) begin
        case (phase_q)
          tla_pkg::PH_BASE: begin
            base_q <= samp_code;
            phase_q <= tla_pkg::PH_MULT;
          end
          tla_pkg::PH_MULT: begin
            phase_q <= tla_pkg::PH_BASE;
            if (last) begin
              res_valid <= 1'b1;
              res_code <= avg_on ? acc_sum[13:tla_pkg::AVG_SHIFT] : diff;
              acc_q <= '0;
              cnt_q <= '0;
            end else begin
              acc_q <= acc_sum;
              cnt_q <= cnt_q + 5'd1;
            end
          end
          default: phase_q <= tla_pkg::PH_BASE;
        endcase
      end
    end
  end
endmodule : tla_remote_avg

/* File: core/tla_core.sv */
// Result store, limit comparison, status flags and alarm output.
// Assumes the host port logic gives one-cycle read and write strobes on core_clk.
`timescale 1ns/1ps
module tla_core (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic conv_valid,
  input wire tla_pkg::tla_conv_type conv,
  input wire logic remote_valid,
  input wire logic [9:0] remote_code,
  input wire tla_pkg::tla_reg_req_type req,
  output logic [7:0] reg_rdata,
  output logic bias_mult,
  output logic alarm
);
  localparam int N = tla_pkg::NUM_CH;

  logic [9:0] res_q [N];
  logic [7:0] hi_lim_q [N];
  logic [7:0] lo_lim_q [N];
  logic [N-1:0] flag_q;
  logic [N-1:0] lock_q;
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [7:0] mask1_q;
  logic [7:0] mask2_q;

  logic rem_valid;
  logic [9:0] rem_code;
  logic avg_on;
  logic [N-1:0] upd;
  logic [9:0] new_code [N];
  logic [N-1:0] viol;
  logic [N-1:0] mask;
  logic [N-1:0] clr;
  logic [N-1:0] lsb_lock;
  logic [7:0] stat1;
  logic [7:0] stat2;
  logic rd_msb;
  logic [7:0] rd_mux;
  logic [7:0] lim_off;

  // Status register that reports a channel: internal, remote and analog 3..4 first, the rest second.
  function automatic logic [7:0] stat_addr(input int chan);
    case (chan)
      tla_pkg::CH_INT, tla_pkg::CH_EXT, 3, 4: stat_addr = tla_pkg::ADDR_STAT1;
      default: stat_addr = tla_pkg::ADDR_STAT2;
    endcase
  endfunction : stat_addr

  // Channel held by an eight-bit result register, or none.
  function automatic logic [3:0] msb_chan(input logic [7:0] addr);
    msb_chan = 4'hf;
    if (addr == tla_pkg::ADDR_MSB_VDD) msb_chan = tla_pkg::CH_VDD;
    if (addr == tla_pkg::ADDR_MSB_INT) msb_chan = tla_pkg::CH_INT;
    if (addr == tla_pkg::ADDR_MSB_EXT) msb_chan = tla_pkg::CH_EXT;
    if (addr >= tla_pkg::ADDR_MSB_AIN3 && addr <= tla_pkg::ADDR_MSB_LAST) begin
      msb_chan = 4'(addr - tla_pkg::ADDR_MSB_AIN3 + 8'h03);
    end
  endfunction : msb_chan

  assign avg_on = ~cfg2_q[tla_pkg::CFG2_AVG_OFF_BIT];

  tla_remote_avg u_remote (
    .core_clk(core_clk),
    .rstn(rstn),
    .samp_valid(remote_valid),
    .samp_code(remote_code),
    .avg_on(avg_on),
    .bias_mult(bias_mult),
    .res_valid(rem_valid),
    .res_code(rem_code)
  );

  generate
    for (genvar c = 0; c < N; c++) begin : g_ch
      logic signed [8:0] r9;
      logic signed [8:0] h9;
      logic signed [8:0] l9;
      logic is_temp;
      assign is_temp = (c == tla_pkg::CH_INT) || (c == tla_pkg::CH_EXT);
      assign upd[c] = (c == tla_pkg::CH_EXT) ? rem_valid : (conv_valid && conv.chan == 4'(c));
      assign new_code[c] = (c == tla_pkg::CH_EXT) ? rem_code : conv.code;
      assign r9 = {is_temp & res_q[c][9], res_q[c][9:2]};
      assign h9 = {is_temp & hi_lim_q[c][7], hi_lim_q[c]};
      assign l9 = {is_temp & lo_lim_q[c][7], lo_lim_q[c]};
      assign viol[c] = (r9 > h9) || (r9 <= l9);
      assign clr[c] = req.rd && (req.addr == stat_addr(c));
    end
  endgenerate

  assign mask = {mask2_q[3:0], mask1_q[7:6], mask1_q[1:0], mask2_q[4]};
  assign stat1 = {flag_q[4:3], 4'h0, flag_q[tla_pkg::CH_EXT], flag_q[tla_pkg::CH_INT]};
  assign stat2 = {3'h0, flag_q[tla_pkg::CH_VDD], flag_q[8:5]};

  assign rd_msb = req.rd && (msb_chan(req.addr) != 4'hf);
  assign lsb_lock = (req.addr == tla_pkg::ADDR_LSB_A) ? 9'h003 :
                    (req.addr == tla_pkg::ADDR_LSB_B) ? 9'h01c :
                    (req.addr == tla_pkg::ADDR_LSB_C) ? 9'h1e0 : 9'h000;
  assign lim_off = req.addr - tla_pkg::ADDR_LIM_BASE;

  always_comb begin
    rd_mux = 8'h00;
    if (req.addr == tla_pkg::ADDR_STAT1) rd_mux = stat1;
    else if (req.addr == tla_pkg::ADDR_STAT2) rd_mux = stat2;
    else if (req.addr == tla_pkg::ADDR_LSB_A) rd_mux = {4'h0, res_q[1][1:0], res_q[0][1:0]};
    else if (req.addr == tla_pkg::ADDR_LSB_B) rd_mux = {res_q[4][1:0], res_q[3][1:0], 2'b00, res_q[2][1:0]};
    else if (req.addr == tla_pkg::ADDR_LSB_C) rd_mux = {res_q[8][1:0], res_q[7][1:0], res_q[6][1:0], res_q[5][1:0]};
    else if (msb_chan(req.addr) != 4'hf) rd_mux = res_q[msb_chan(req.addr)][9:2];
    else if (req.addr == tla_pkg::ADDR_CFG1) rd_mux = cfg1_q;
    else if (req.addr == tla_pkg::ADDR_CFG2) rd_mux = cfg2_q;
    else if (req.addr == tla_pkg::ADDR_MASK1) rd_mux = mask1_q;
    else if (req.addr == tla_pkg::ADDR_MASK2) rd_mux = mask2_q;
    else if (req.addr >= tla_pkg::ADDR_LIM_BASE && req.addr <= tla_pkg::ADDR_LIM_LAST) begin
      rd_mux = lim_off[0] ? lo_lim_q[lim_off[4:1]] : hi_lim_q[lim_off[4:1]];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // Freeze high bytes after a low read.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lock_q <= '0;
    end else if (rd_msb) begin
      lock_q <= '0;
    end else if (req.rd) begin
      lock_q <= lock_q | lsb_lock;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int c = 0; c < N; c++) begin
        res_q[c] <= tla_pkg::RES_RESET;
      end
    end else begin
      for (int c = 0; c < N; c++) begin
        if (upd[c] && !lock_q[c]) begin
          res_q[c] <= new_code[c];
        end
      end
    end
  end

  // Flags set win over read clear.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flag_q <= '0;
    end else begin
      for (int c = 0; c < N; c++) begin
        if (viol[c] && !mask[c]) begin
          flag_q[c] <= 1'b1;
        end else if (clr[c]) begin
          flag_q[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cfg1_q <= tla_pkg::CFG_RESET;
      cfg2_q <= tla_pkg::CFG_RESET;
      mask1_q <= tla_pkg::MASK_RESET;
      mask2_q <= tla_pkg::MASK_RESET;
      for (int c = 0; c < N; c++) begin
        hi_lim_q[c] <= tla_pkg::HIGH_LIM_RESET;
        lo_lim_q[c] <= tla_pkg::LOW_LIM_RESET;
      end
    end else if (req.wr) begin
      if (req.addr == tla_pkg::ADDR_CFG1) cfg1_q <= req.wdata;
      if (req.addr == tla_pkg::ADDR_CFG2) cfg2_q <= req.wdata;
      if (req.addr == tla_pkg::ADDR_MASK1) mask1_q <= req.wdata;
      if (req.addr == tla_pkg::ADDR_MASK2) mask2_q <= req.wdata;
      if (req.addr >= tla_pkg::ADDR_LIM_BASE && req.addr <= tla_pkg::ADDR_LIM_LAST) begin
        if (lim_off[0]) lo_lim_q[lim_off[4:1]] <= req.wdata;
        else hi_lim_q[lim_off[4:1]] <= req.wdata;
      end
    end
  end

  // Polarity-selectable alarm; a register keeps the pin glitch free.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      alarm <= 1'b0;
    end else begin
      alarm <= (|flag_q) ~^ cfg1_q[tla_pkg::CFG1_POL_BIT];
    end
  end
endmodule : tla_core

/* File: sim/tla_core_sva_sva.sv */
// Port checker of the limit alarm core.
// Assumes binding to tla_core; it shadows the few registers it needs.
`timescale 1ns/1ps
module tla_core_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic conv_valid,
  input wire tla_pkg::tla_conv_type conv,
  input wire logic remote_valid,
  input wire tla_pkg::tla_reg_req_type req,
  input wire logic [7:0] reg_rdata,
  input wire logic bias_mult,
  input wire logic alarm
);
  logic pol_q, msk_q, lk_q;
  logic [7:0] hi_q, lo_q;
  // Results that arrive under a low-byte lock are dropped, so they cannot raise the alarm.
  wire logic hit = conv_valid && conv.chan == tla_pkg::CH_INT && !msk_q && !lk_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pol_q <= 1'b0;
      msk_q <= 1'b0;
      hi_q <= 8'h7f;
      lo_q <= 8'h80;
    end else if (req.wr) begin
      if (req.addr == 8'h18) pol_q <= req.wdata[3];
      if (req.addr == 8'h1d) msk_q <= req.wdata[0];
      if (req.addr == 8'h32) hi_q <= req.wdata;
      if (req.addr == 8'h33) lo_q <= req.wdata;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lk_q <= 1'b0;
    end else if (req.rd && req.addr inside {[8'h06:8'h08], [8'h0a:8'h0f]}) begin
      lk_q <= 1'b0;
    end else if (req.rd && req.addr == 8'h03) begin
      lk_q <= 1'b1;
    end
  end
  a_bias_flip: assert property (remote_valid |=> bias_mult != $past(bias_mult))
    else $error("bias did not flip");
  a_bias_hold: assert property (!remote_valid |=> $stable(bias_mult))
    else $error("bias moved");
  a_unmapped_zero: assert property (req.rd && req.addr == 8'h02 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_stands: assert property (!req.rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_high_alarm: assert property (hit && $signed(conv.code[9:2]) > $signed(hi_q) |-> ##3 alarm == pol_q)
    else $error("high violation without alarm");
  a_low_alarm: assert property (hit && $signed(conv.code[9:2]) <= $signed(lo_q) |-> ##3 alarm == pol_q)
    else $error("low violation without alarm");
  a_limit_read: assert property (req.rd && req.addr == 8'h32 |=> reg_rdata == $past(hi_q))
    else $error("limit readback wrong");
  a_alarm_idle: assert property ($rose(rstn) |=> alarm == 1'b1)
    else $error("alarm not idle after reset");
endmodule : tla_core_sva
bind tla_core tla_core_sva u_sva (.core_clk(core_clk), .rstn(rstn), .conv_valid(conv_valid), .conv(conv),
  .remote_valid(remote_valid), .req(req), .reg_rdata(reg_rdata), .bias_mult(bias_mult), .alarm(alarm));

/* File: sim/tla_diode_model.sv */
// Behavioural remote diode: one front-end sample every four clocks.
// Assumes the core flips bias_mult after each sample that it takes.
`timescale 1ns/1ps
module tla_diode_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [9:0] delta,
  input wire logic bias_mult,
  output logic remote_valid,
  output logic [9:0] remote_code,
  output logic last_hi
);
  logic [1:0] cnt_q;
  logic hi_q;
  logic [9:0] last_q;
  wire logic [9:0] samp = bias_mult ? 10'h0a0 + delta + (hi_q ? 10'h008 : 10'h000) : 10'h0a0;
  // The code is garbage between samples so nothing can lean on a stale value.
  assign remote_code = remote_valid ? samp : ~last_q;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
      hi_q <= 1'b0;
      last_q <= 10'h000;
      last_hi <= 1'b0;
      remote_valid <= 1'b0;
    end else begin
      cnt_q <= run ? cnt_q + 2'h1 : cnt_q;
      remote_valid <= run && cnt_q == 2'h3;
      if (remote_valid) last_q <= samp;
      if (remote_valid && bias_mult) hi_q <= !hi_q;
      if (remote_valid && bias_mult) last_hi <= hi_q;
    end
  end
endmodule : tla_diode_model

/* File: sim/tb_temp_result_limit_alarm.sv */
// Self-checking bench of the limit alarm core.
// Assumes the diode model on the remote port and the bound checker.
`timescale 1ns/1ps
module tb_temp_result_limit_alarm;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic conv_valid = 1'b0;
  tla_pkg::tla_conv_type conv = '0;
  tla_pkg::tla_reg_req_type req = '0;
  logic run = 1'b0;
  logic remote_valid, bias_mult, alarm, last_hi;
  logic [9:0] remote_code;
  logic [7:0] reg_rdata;
  logic [31:0] lfsr = 32'h0000_86c6;
  int failures = 0;
  int check_count = 0;
  localparam logic [9:0] TAB [3] = '{10'h360, 10'h001, 10'h1f4};
  localparam logic [9:0] LT [5] = '{10'h064, 10'h068, 10'h3d8, 10'h3dc, 10'h000};
  localparam logic [4:0] LF = 5'b0_0110;
  localparam logic [7:0] DEG [3] = '{8'hd8, 8'h00, 8'h7d};
  tla_core u_dut (.core_clk(core_clk), .rstn(rstn), .conv_valid(conv_valid), .conv(conv),
    .remote_valid(remote_valid), .remote_code(remote_code), .req(req), .reg_rdata(reg_rdata),
    .bias_mult(bias_mult), .alarm(alarm));
  tla_diode_model u_diode (.core_clk(core_clk), .rstn(rstn), .run(run), .delta(10'h060),
    .bias_mult(bias_mult), .remote_valid(remote_valid), .remote_code(remote_code), .last_hi(last_hi));
  initial forever #50 core_clk = ~core_clk;
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // Whole degrees as a reader works them out from a ten-bit code.
  function automatic logic [7:0] code_deg(logic [9:0] c);
    int q;
    q = c[9] ? int'(c[8:0]) - 512 : int'(c);
    return 8'(q / 4);
  endfunction : code_deg
  task automatic end_of_test;
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk8(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge core_clk);
    req.wr = 1'b0;
    @(negedge core_clk);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge core_clk);
    req.rd = 1'b0;
    chk8(reg_rdata, exp);
    @(negedge core_clk);
  endtask : rd
  task automatic cv(logic [3:0] ch, logic [9:0] c);
    conv = '{chan: ch, code: c};
    conv_valid = 1'b1;
    @(negedge core_clk);
    conv_valid = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : cv
  initial begin
    repeat (5000) @(negedge core_clk);
    failures++;
    end_of_test();
  end
  initial begin
    logic [9:0] code;
    logic pf;
    logic [7:0] msb;
    repeat (5) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    wr(8'h1d, 8'hc0);
    wr(8'h1e, 8'h1f);
    rd(8'h00, 8'hc0);
    rd(8'h01, 8'h1f);
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h00);
    chk8({7'h00, alarm}, 8'h01);
    rd(8'h33, 8'h80);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      code = (i < 3) ? TAB[i] : {2'b00, lfsr[7:0]};
      cv(tla_pkg::CH_INT, code);
      rd(8'h07, code[9:2]);
      msb = reg_rdata;
      rd(8'h03, {4'h0, code[1:0], 2'b00});
      if (i < 3) chk8(code_deg({msb, reg_rdata[3:2]}), DEG[i]);
      cv(tla_pkg::CH_INT, ~code);
      rd(8'h07, code[9:2]);
    end
    wr(8'h32, 8'h19);
    rd(8'h32, 8'h19);
    wr(8'h33, 8'hf6);
    // The last random code may already break the new high limit, and the flag sticks.
    pf = $signed(code[9:2]) > $signed(8'h19);
    for (int i = 0; i < 5; i++) begin
      cv(tla_pkg::CH_INT, LT[i]);
      rd(8'h00, {7'h00, pf | LF[i]});
      rd(8'h00, {7'h00, LF[i]});
      chk8({7'h00, alarm}, {7'h00, !LF[i]});
      pf = LF[i];
    end
    wr(8'h1d, 8'hc1);
    cv(tla_pkg::CH_INT, 10'h068);
    rd(8'h00, 8'h00);
    chk8({7'h00, alarm}, 8'h01);
    wr(8'h1d, 8'hc0);
    wr(8'h18, 8'h08);
    cv(tla_pkg::CH_INT, 10'h000);
    cv(tla_pkg::CH_VDD, 10'h3fc);
    wr(8'h1e, 8'h0f);
    repeat (3) @(negedge core_clk);
    rd(8'h01, 8'h10);
    rd(8'h01, 8'h10);
    chk8({7'h00, alarm}, 8'h01);
    wr(8'h1e, 8'h1f);
    run = 1'b1;
    repeat (300) @(negedge core_clk);
    rd(8'h08, 8'h19);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h19);
    wr(8'h19, 8'h20);
    repeat (40) @(negedge core_clk);
    run = 1'b0;
    repeat (20) @(negedge core_clk);
    rd(8'h08, last_hi ? 8'h1a : 8'h18);
    end_of_test();
  end
endmodule : tb_temp_result_limit_alarm
